// file: design/iara_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Eight-bit N field sets the pixel clock divider denominator.
// - Override bit set: programmed M and N drive the divider.
// - Override clear: divisor reads return automatically derived setting.
// - Automatic M/N follow lane count, bytes per pixel, dual mode.
// - Indirect control, offset, data sit at three consecutive locations.
// - Control 0x10 selects D-PHY block, 0x14 serial-link block, writes.
// - Control 0x11 or 0x15 selects block for reads; low bit reads.
// - Write: select block, set offset, data write commits to block.
// - Read: select block, set offset, data read returns location.
// - Auto-increment advances offset after every data read, and after data writes with low strobe set.
// - Port 0 polarity bit 1: 0 normal clock, 1 inverted clock.
// - Port 0 polarity register resets to 8h, inversion bit 0.
// - Override at bit 7, M at bits 4..0 of register below N.
// - Port 1 has own polarity register, bit 1, reset 8h.
module iara_regs
	import iara_pkg::*;
(
	input  wire logic           aclk,
	input  wire logic           aresetn,
	input  wire logic [9:0]     s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	input  wire logic [9:0]     s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready,
	input  wire logic [2:0]     lane_count,
	input  wire logic [1:0]     bytes_per_pixel,
	input  wire logic           dual_mode,
	output iara_pkg::iara_div_s pclk_div,
	output logic                port0_clk_invert,
	output logic                port1_clk_invert
);
	import iara_pkg::*;

	typedef struct packed {
		iara_state_e state;
		logic [9:0]  awaddr;
		logic        aw_held;
		logic [31:0] wdata;
		logic        w_b0;
		logic        w_held;
		logic [1:0]  bresp;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        ov;
		iara_div_s   div;
		logic [7:0]  ctl;
		logic [7:0]  ofs;
		logic [7:0]  pol0;
		logic [7:0]  pol1;
		logic [7:0]  auto_cfg;
		iara_div_s   out_div;
		logic        inv0;
		logic        inv1;
	} iara_regs_s;

	iara_regs_s st_reg;
	iara_regs_s st_next;
	iara_div_s  auto_div;

	// Divider derived from the link setup; used while the override is clear
	iara_auto_div u_auto_div (
		.lane_count      (lane_count),
		.bytes_per_pixel (bytes_per_pixel),
		.dual_mode       (dual_mode),
		.auto_div        (auto_div)
	);

	// Word index of a byte address; misaligned low bits ignored
	function automatic logic [7:0] word_index(input logic [9:0] addr);
		word_index = addr[9:2];
	endfunction : word_index

	// Indirect target decode: both address and block must match
	function automatic logic [1:0] ind_hit(input logic [7:0] ctl, input logic [7:0] ofs);
		logic dphy;
		dphy = ((ctl & IARA_CTL_SEL_MASK) == (IARA_SEL_DPHY_WR & IARA_CTL_SEL_MASK));
		ind_hit = 2'b00;
		if (dphy && ofs == IARA_IND_PORT0_POL) begin
			ind_hit = 2'b01;
		end else if (dphy && ofs == IARA_IND_PORT1_POL) begin
			ind_hit = 2'b10;
		end
	endfunction : ind_hit

	// Offset after a data access; wraps at the top of the indirect space
	function automatic logic [7:0] next_offset(input logic [7:0] ofs, input logic ainc);
		next_offset = ainc ? ofs + 8'h01 : ofs;
	endfunction : next_offset

	// Indices that answer OKAY; any other word in the window is an error
	function automatic logic reg_known(input logic [7:0] idx);
		case (idx)
			IARA_IDX_DIV_M, IARA_IDX_DIV_N, IARA_IDX_IND_CTL,
			IARA_IDX_IND_OFS, IARA_IDX_IND_DATA, IARA_IDX_AUTO_CFG: reg_known = 1'b1;
			default: reg_known = 1'b0;
		endcase
	endfunction : reg_known

	logic [7:0]  ind_rd;
	logic [7:0]  rd_byte;
	logic        rd_ok;
	logic        do_wr;
	logic [7:0]  wr_idx;
	logic [7:0]  wb;
	logic [1:0]  rd_hit;
	logic [1:0]  wr_hit;

	always_comb begin
		st_next = st_reg;
		wr_idx  = word_index(st_reg.awaddr);
		wb      = st_reg.wdata[7:0];
		do_wr   = 1'b0;
		rd_byte = 8'h00;
		rd_ok   = 1'b1;
		rd_hit  = ind_hit(st_reg.ctl, st_reg.ofs);
		wr_hit  = ind_hit(st_reg.ctl, st_reg.ofs);

		// Indirect read mux; serial-link block and undefined offsets read zero
		case (rd_hit)
			2'b01:   ind_rd = st_reg.pol0;
			2'b10:   ind_rd = st_reg.pol1;
			default: ind_rd = 8'h00;
		endcase

		if (s_axi_awvalid && s_axi_awready) begin
			st_next.awaddr  = s_axi_awaddr;
			st_next.aw_held = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.wdata  = s_axi_wdata;
			st_next.w_b0   = s_axi_wstrb[0];
			st_next.w_held = 1'b1;
		end

		case (st_reg.state)
			IARA_ST_IDLE: begin
				if (st_reg.aw_held && st_reg.w_held) begin
					do_wr           = st_reg.w_b0;
					st_next.aw_held = 1'b0;
					st_next.w_held  = 1'b0;
					st_next.bresp   = IARA_RESP_OKAY;
					st_next.state   = IARA_ST_WRSP;
					if (!reg_known(wr_idx)) begin
						do_wr         = 1'b0;
						st_next.bresp = IARA_RESP_SLVERR;
					end
				end else if (s_axi_arvalid) begin
					rd_ok = reg_known(word_index(s_axi_araddr));
					case (word_index(s_axi_araddr))
						IARA_IDX_DIV_M: begin
							rd_byte = {st_reg.ov, 2'b00,
								st_reg.ov ? st_reg.div.m : auto_div.m};
						end
						IARA_IDX_DIV_N: begin
							rd_byte = st_reg.ov ? st_reg.div.n : auto_div.n;
						end
						IARA_IDX_IND_CTL:  rd_byte = st_reg.ctl;
						IARA_IDX_IND_OFS:  rd_byte = st_reg.ofs;
						IARA_IDX_IND_DATA: begin
							rd_byte = ind_rd;
							st_next.ofs = next_offset(st_reg.ofs, st_reg.ctl[IARA_CTL_AINC_BIT]);
						end
						IARA_IDX_AUTO_CFG: rd_byte = st_reg.auto_cfg;
						default: rd_byte = 8'h00;
					endcase
					st_next.rdata = {24'h000000, rd_byte};
					st_next.rresp = rd_ok ? IARA_RESP_OKAY : IARA_RESP_SLVERR;
					st_next.state = IARA_ST_RRSP;
				end
			end
			IARA_ST_WRSP: begin
				if (s_axi_bready) begin
					st_next.state = IARA_ST_IDLE;
				end
			end
			IARA_ST_RRSP: begin
				if (s_axi_rready) begin
					st_next.state = IARA_ST_IDLE;
				end
			end
			default: st_next.state = IARA_ST_IDLE;
		endcase

		if (do_wr) begin
			case (wr_idx)
				IARA_IDX_DIV_M: begin
					st_next.ov    = wb[IARA_OV_BIT];
					st_next.div.m = wb[IARA_M_MSB:0];
				end
				IARA_IDX_DIV_N:    st_next.div.n = wb;
				IARA_IDX_IND_CTL:  st_next.ctl = wb;
				IARA_IDX_IND_OFS:  st_next.ofs = wb;
				IARA_IDX_IND_DATA: begin
					// Read-mode selection blocks the commit
					if (!st_reg.ctl[IARA_CTL_READ_BIT]) begin
						if (wr_hit == 2'b01) begin
							st_next.pol0 = wb;
						end
						if (wr_hit == 2'b10) begin
							st_next.pol1 = wb;
						end
					end
					st_next.ofs = next_offset(st_reg.ofs, st_reg.ctl[IARA_CTL_AINC_BIT]);
				end
				IARA_IDX_AUTO_CFG: st_next.auto_cfg = wb;
				default: begin
				end
			endcase
		end

		// Divider output registered one cycle behind the override, programmed divider and auto inputs
		st_next.out_div = st_reg.ov ? st_reg.div : auto_div;
		st_next.inv0    = st_reg.pol0[IARA_POL_BIT];
		st_next.inv1    = st_reg.pol1[IARA_POL_BIT];

		if (!aresetn) begin
			st_next          = '0;
			st_next.state    = IARA_ST_IDLE;
			st_next.ctl      = IARA_CTL_RESET;
			st_next.ofs      = IARA_OFS_RESET;
			st_next.div.m    = IARA_M_RESET;
			st_next.div.n    = IARA_N_RESET;
			st_next.pol0     = IARA_POL_RESET;
			st_next.pol1     = IARA_POL_RESET;
			st_next.auto_cfg = IARA_AUTO_RESET;
		end
	end

	always_ff @(posedge aclk) begin
		st_reg <= st_next;
	end

	// One transaction at a time; holding registers back-pressure the master
	assign s_axi_awready = (st_reg.state == IARA_ST_IDLE) && !st_reg.aw_held && aresetn;
	assign s_axi_wready  = (st_reg.state == IARA_ST_IDLE) && !st_reg.w_held && aresetn;
	assign s_axi_arready = (st_reg.state == IARA_ST_IDLE) && !(st_reg.aw_held && st_reg.w_held)
		&& aresetn;
	assign s_axi_bvalid  = (st_reg.state == IARA_ST_WRSP);
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_rvalid  = (st_reg.state == IARA_ST_RRSP);
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;

	assign pclk_div         = st_reg.out_div;
	assign port0_clk_invert = st_reg.inv0;
	assign port1_clk_invert = st_reg.inv1;

endmodule : iara_regs

// file: inc/iara_pkg.sv
package iara_pkg;

	// Register word indices; the bus byte address is four times the index
	localparam logic [7:0] IARA_IDX_DIV_M    = 8'h3a;
	localparam logic [7:0] IARA_IDX_DIV_N    = 8'h3b;
	localparam logic [7:0] IARA_IDX_IND_CTL  = 8'h40;
	localparam logic [7:0] IARA_IDX_IND_OFS  = 8'h41;
	localparam logic [7:0] IARA_IDX_IND_DATA = 8'h42;
	localparam logic [7:0] IARA_IDX_AUTO_CFG = 8'h3c;

	// Indirect analog offsets
	localparam logic [7:0] IARA_IND_PORT0_POL = 8'h86;
	localparam logic [7:0] IARA_IND_PORT1_POL = 8'h94;

	// Control register codes and fields
	localparam logic [7:0] IARA_SEL_DPHY_WR  = 8'h10;
	localparam logic [7:0] IARA_SEL_DPHY_RD  = 8'h11;
	localparam logic [7:0] IARA_SEL_LINK_WR  = 8'h14;
	localparam logic [7:0] IARA_SEL_LINK_RD  = 8'h15;
	localparam int         IARA_CTL_READ_BIT = 0;
	localparam int         IARA_CTL_AINC_BIT = 1;
	localparam logic [7:0] IARA_CTL_SEL_MASK = 8'hfc;

	// Divider and polarity fields
	localparam int         IARA_OV_BIT      = 7;
	localparam int         IARA_M_MSB       = 4;
	localparam int         IARA_POL_BIT     = 1;

	// Reset values
	localparam logic [7:0] IARA_POL_RESET   = 8'h08;
	localparam logic [7:0] IARA_CTL_RESET   = 8'h00;
	localparam logic [7:0] IARA_OFS_RESET   = 8'h00;
	localparam logic [4:0] IARA_M_RESET     = 5'h00;
	localparam logic [7:0] IARA_N_RESET     = 8'h00;
	localparam logic [7:0] IARA_AUTO_RESET  = 8'h04;

	localparam logic [1:0] IARA_RESP_OKAY   = 2'b00;
	localparam logic [1:0] IARA_RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [4:0] m;
		logic [7:0] n;
	} iara_div_s;

	typedef enum logic [2:0] {
		IARA_ST_IDLE = 3'b001,
		IARA_ST_WRSP = 3'b010,
		IARA_ST_RRSP = 3'b100
	} iara_state_e;

endpackage : iara_pkg

// file: design/iara_auto_div.sv
`timescale 1ns/100ps
module iara_auto_div
	import iara_pkg::*;
(
	input  wire logic [2:0]     lane_count,
	input  wire logic [1:0]     bytes_per_pixel,
	input  wire logic           dual_mode,
	output iara_pkg::iara_div_s auto_div
);
	import iara_pkg::*;

	logic [3:0] lanes_total;
	logic [4:0] m_raw;

	// Pixel rate = byte rate * lanes / bytes per pixel; M counts lanes, N bytes
	always_comb begin
		lanes_total = dual_mode ? {lane_count, 1'b0} : {1'b0, lane_count};
		m_raw = (lanes_total == 4'h0) ? 5'h01 : {1'b0, lanes_total};
		auto_div.m = m_raw;
		auto_div.n = (bytes_per_pixel == 2'h0) ? 8'h03 : {6'h00, bytes_per_pixel};
	end

endmodule : iara_auto_div

// file: verif/iara_regs_asserts.sv
`timescale 1ns/100ps
module iara_regs_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        port0_clk_invert,
	input wire logic        port1_clk_invert
);
	import iara_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_w_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	property p_r_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	property p_busy; s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_arready;
	endproperty
	property p_err; s_axi_rvalid && s_axi_rresp == IARA_RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	// Own disable: the antecedent is the reset itself
	property p_pol_rst;
		disable iff (1'b0) !aresetn |=> !port0_clk_invert && !port1_clk_invert;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	a_r_hold: assert property (p_r_hold) else $error("read response changed early");
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	a_w_lat: assert property (p_w_lat) else $error("write answer timing wrong");
	a_r_hi: assert property (p_r_hi) else $error("read upper bits not zero");
	a_busy: assert property (p_busy) else $error("request taken during response");
	a_err: assert property (p_err) else $error("error read data not zero");
	a_pol_rst: assert property (p_pol_rst) else $error("polarity not reset");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == IARA_RESP_SLVERR);
	c_inv: cover property (port0_clk_invert && port1_clk_invert);
endmodule : iara_regs_asserts

bind iara_regs iara_regs_asserts i_chk (.*);

// file: verif/indirect_analog_reg_access_tb_top.sv
`timescale 1ns/100ps
module indirect_analog_reg_access_tb_top;
	import iara_pkg::*;
	typedef struct packed {
		logic       wr;
		logic [7:0] idx;
		logic [7:0] dat;
		logic [1:0] rsp;
	} iara_row_s;
	localparam logic [1:0] OK = IARA_RESP_OKAY;
	localparam logic [1:0] ER = IARA_RESP_SLVERR;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, dual_mode = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic port0_clk_invert, port1_clk_invert;
	logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bytes_per_pixel = 2'd2;
	logic [2:0]  lane_count = 3'd4;
	iara_div_s   pclk_div;
	int          failures = 0, cmp_count = 0, stall = 0;
	iara_row_s   rows [20] = '{
		'{1'b0,8'h40,8'h00,OK}, '{1'b0,8'h41,8'h00,OK}, '{1'b0,8'h3c,8'h04,OK},
		'{1'b1,8'h40,8'h11,OK}, '{1'b1,8'h41,8'h86,OK}, '{1'b0,8'h42,8'h08,OK},
		'{1'b1,8'h41,8'h94,OK}, '{1'b0,8'h42,8'h08,OK}, '{1'b1,8'h40,8'h10,OK},
		'{1'b1,8'h41,8'h86,OK}, '{1'b1,8'h42,8'h0a,OK}, '{1'b1,8'h40,8'h11,OK},
		'{1'b0,8'h42,8'h0a,OK}, '{1'b0,8'h42,8'h0a,OK}, '{1'b1,8'h40,8'h14,OK},
		'{1'b0,8'h40,8'h14,OK}, '{1'b1,8'h40,8'h15,OK}, '{1'b0,8'h42,8'h00,OK},
		'{1'b1,8'h7f,8'h00,ER}, '{1'b0,8'h7f,8'h00,ER}
	};
	iara_regs i_dut (.*);
	always #2 aclk = ~aclk;
	task ck(input string nm, input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : ck
	task summarize;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic acc(input logic wr, input logic [7:0] i, d, input logic [1:0] e);
		int n;
		logic a, w, b;
		logic [1:0] r;
		logic [31:0] q;
		if (wr) begin
			s_axi_awaddr <= {i, 2'b00};
			s_axi_wdata <= {24'h0, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
		end else begin
			s_axi_araddr <= {i, 2'b00};
			s_axi_arvalid <= 1'b1;
		end
		for (n = 0; n < 40; n++) begin
			// Mid-cycle look: readies are settled until the next edge
			@(negedge aclk);
			a = wr ? s_axi_awready : s_axi_arready;
			w = s_axi_wready;
			b = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
			r = wr ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge aclk);
			if (a && wr) s_axi_awvalid <= 1'b0;
			if (a && !wr) s_axi_arvalid <= 1'b0;
			if (w && wr) s_axi_wvalid <= 1'b0;
			s_axi_bready <= wr && n >= stall && !b;
			s_axi_rready <= !wr && n >= stall && !b;
			if (b) break;
		end
		if (n == 40) begin
			failures++;
			summarize();
		end
		ck("resp", r, e);
		if (!wr) ck("rdata", q, {24'h0, d});
	endtask : acc
	task automatic acc_row(input iara_row_s rw);
		acc(rw.wr, rw.idx, rw.dat, rw.rsp);
	endtask : acc_row
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[k]) acc_row(rows[k]);
		@(negedge aclk);
		ck("inv0", port0_clk_invert, 1'b1);
		ck("inv1", port1_clk_invert, 1'b0);
		@(posedge aclk);
		acc(1'b1, 8'h40, 8'h13, OK);
		acc(1'b1, 8'h41, 8'h86, OK);
		acc(1'b0, 8'h42, 8'h0a, OK);
		acc(1'b0, 8'h41, 8'h87, OK);
		acc(1'b1, 8'h40, 8'h12, OK);
		acc(1'b1, 8'h41, 8'h94, OK);
		acc(1'b1, 8'h42, 8'h0a, OK);
		acc(1'b0, 8'h41, 8'h95, OK);
		@(negedge aclk);
		ck("inv1", port1_clk_invert, 1'b1);
		@(posedge aclk);
		stall = 3;
		acc(1'b0, 8'h3a, 8'h04, OK);
		acc(1'b0, 8'h3b, 8'h02, OK);
		dual_mode <= 1'b1;
		lane_count <= 3'd3;
		repeat (2) @(posedge aclk);
		acc(1'b0, 8'h3a, 8'h06, OK);
		acc(1'b1, 8'h3a, 8'h9f, OK);
		acc(1'b1, 8'h3b, 8'hc3, OK);
		acc(1'b0, 8'h3a, 8'h9f, OK);
		acc(1'b0, 8'h3b, 8'hc3, OK);
		@(negedge aclk);
		ck("div", pclk_div, {5'h1f, 8'hc3});
		@(posedge aclk);
		acc(1'b1, 8'h3a, 8'h05, OK);
		acc(1'b0, 8'h3b, 8'h02, OK);
		acc(1'b0, 8'h3a, 8'h06, OK);
		@(negedge aclk);
		ck("div", pclk_div, {5'h06, 8'h02});
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		ck("inv0", port0_clk_invert, 1'b0);
		ck("inv1", port1_clk_invert, 1'b0);
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		acc(1'b0, 8'h40, 8'h00, OK);
		// Data write under a read selection must not reach the block
		acc(1'b1, 8'h40, 8'h11, OK);
		acc(1'b1, 8'h41, 8'h86, OK);
		acc(1'b1, 8'h42, 8'h02, OK);
		acc(1'b0, 8'h42, 8'h08, OK);
		acc(1'b1, 8'h41, 8'h94, OK);
		acc(1'b0, 8'h42, 8'h08, OK);
		// Low byte strobe clear: write answered but nothing stored
		s_axi_wstrb <= 4'he;
		acc(1'b1, 8'h41, 8'h55, OK);
		s_axi_wstrb <= 4'hf;
		acc(1'b0, 8'h41, 8'h94, OK);
		lane_count <= 3'd0;
		bytes_per_pixel <= 2'd0;
		repeat (2) @(posedge aclk);
		acc(1'b0, 8'h3a, 8'h01, OK);
		acc(1'b0, 8'h3b, 8'h03, OK);
		@(negedge aclk);
		ck("div", pclk_div, {5'h01, 8'h03});
		summarize();
	end
endmodule : indirect_analog_reg_access_tb_top
